//--- rtl/disp_scaler.sv
// zero-extends a displacement and scales it by the operand size (x1/x2/x4)
module disp_scaler #(
  parameter int unsigned DISP_W = 8
) (
  input  wire logic [DISP_W-1:0]    disp_in,
  input  wire ea_gen_pkg::op_size_t size_in,
  output wire logic [31:0]          scaled_out
);
  wire logic [31:0] disp_zx;
  wire logic [1:0]  shift_amt;
  assign disp_zx    = {{(32-DISP_W){1'b0}}, disp_in};
  // quadword never uses a displacement; it is held to longword scaling
  assign shift_amt  = (size_in == ea_gen_pkg::SIZE_QUAD) ? 2'h2 : 2'(size_in);
  assign scaled_out = disp_zx << shift_amt;
endmodule

//--- rtl/ea_gen_pkg.sv
package ea_gen_pkg;

  localparam int unsigned DATA_W = 32;

  typedef enum logic [3:0] {
    MODE_REG_DIRECT,
    MODE_REG_INDIRECT,
    MODE_POST_INC,
    MODE_PRE_DEC,
    MODE_REG_DISP4,
    MODE_INDEXED_REG,
    MODE_GBR_DISP8,
    MODE_INDEXED_GBR,
    MODE_PC_DISP8,
    MODE_BRANCH_DISP8,
    MODE_BRANCH_DISP12,
    MODE_BRANCH_REG,
    MODE_IMM_ZERO,
    MODE_IMM_SIGN,
    MODE_IMM_TRAP
  } addr_mode_t;

  typedef enum logic [1:0] {
    SIZE_BYTE,
    SIZE_WORD,
    SIZE_LONG,
    SIZE_QUAD
  } op_size_t;

  typedef enum logic [1:0] {
    RESULT_NONE,
    RESULT_OPERAND,
    RESULT_MEM_ADDR,
    RESULT_BRANCH
  } result_kind_t;

  localparam logic [31:0] PC_AHEAD       = 32'h0000_0004;
  localparam logic [31:0] LONG_ALIGN_MSK = 32'hFFFF_FFFC;
  localparam int unsigned TRAP_SHIFT     = 2;
  localparam int unsigned BRANCH_SHIFT   = 1;
  localparam logic [31:0] RESET_WORD     = 32'h0000_0000;
  localparam logic [7:0]  RESET_ADDRESS_SPACE_ID     = 8'h00;

endpackage

//--- rtl/effective_address_generator.sv
// What this block does
// - register direct: operand is the selected register, no address, no memory access
// - post-increment: address is old register, then register plus 1/2/4/8
// - predecrement: register minus 1/2/4/8 written back and used as address
// - register plus zero-extended 4-bit displacement scaled 1/2/4
// - indexed register: base register plus index register zero
// - global base plus zero-extended 8-bit displacement scaled 1/2/4
// - indexed global: global base plus index register zero
// - pc-relative load: zero-extended 8-bit disp scaled 2/4 plus pc plus 4
// - longword pc-relative load clears the two low pc bits first
// - short branch: sign-extended 8-bit disp times 2 plus pc plus 4
// - long branch: sign-extended 12-bit disp times 2 plus pc plus 4
// - immediate zero-extended for bit-test, and, or, exclusive-or
// - immediate sign-extended for move, add and compare-equal
// - trap immediate zero-extended and multiplied by 4
// - with translation enabled every memory-access address is flagged for translation; branch targets are not
// - multiple virtual spaces: address space id presented with translated access
// - pc used is the instruction address captured at its start
module effective_address_generator (
  input  wire logic                   core_clk_in,
  input  wire logic                   srst_in,
  input  wire logic                   start_in,
  input  wire ea_gen_pkg::addr_mode_t mode_in,
  input  wire ea_gen_pkg::op_size_t   size_in,
  input  wire logic [31:0]            selected_general_reg_in,
  input  wire logic [31:0]            index_reg_zero_in,
  input  wire logic [31:0]            global_base_reg_in,
  input  wire logic [31:0]            pc_in,
  input  wire logic [11:0]            disp_imm_in,
  input  wire logic                   addr_translate_enable_in,
  input  wire logic                   single_virtual_space_in,
  input  wire logic [31:0]            page_entry_high_reg_in,
  output logic                        valid_out,
  output ea_gen_pkg::result_kind_t    kind_out,
  output logic [31:0]                 result_out,
  output logic                        mem_access_out,
  output logic                        base_wb_out,
  output logic [31:0]                 base_wb_value_out,
  output logic                        translate_out,
  output logic                        address_space_id_valid_out,
  output logic [7:0]                  address_space_id_out
);

  // pc of the instruction in flight, taken at start_in
  logic [31:0] pc_q;
  wire  [31:0] pc_now;
  assign pc_now = start_in ? pc_in : pc_q;

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      pc_q <= ea_gen_pkg::RESET_WORD;
    end else if (start_in) begin
      pc_q <= pc_in;
    end
  end

  wire [31:0] size_bytes;
  wire [31:0] disp4_scaled;
  wire [31:0] disp8_scaled;
  wire [31:0] pc_disp_scaled;
  wire ea_gen_pkg::op_size_t pc_size;

  size_step u_step (
    .size_in  (size_in),
    .step_out (size_bytes)
  );

  disp_scaler #(.DISP_W(4)) u_disp4 (
    .disp_in    (disp_imm_in[3:0]),
    .size_in    (size_in),
    .scaled_out (disp4_scaled)
  );

  disp_scaler #(.DISP_W(8)) u_disp8 (
    .disp_in    (disp_imm_in[7:0]),
    .size_in    (size_in),
    .scaled_out (disp8_scaled)
  );

  // pc-relative loads exist only as word or longword
  assign pc_size = (size_in == ea_gen_pkg::SIZE_WORD) ? ea_gen_pkg::SIZE_WORD
                                                      : ea_gen_pkg::SIZE_LONG;

  disp_scaler #(.DISP_W(8)) u_disp_pc (
    .disp_in    (disp_imm_in[7:0]),
    .size_in    (pc_size),
    .scaled_out (pc_disp_scaled)
  );

  // all sums are 32 bits wide, so carries fall off the top
  wire [31:0] post_inc_val;
  wire [31:0] pre_dec_val;
  wire [31:0] reg_disp_ea;
  wire [31:0] idx_reg_ea;
  wire [31:0] gbr_disp_ea;
  wire [31:0] idx_gbr_ea;
  wire [31:0] pc_base;
  wire [31:0] pc_load_ea;
  wire [31:0] br8_off;
  wire [31:0] br12_off;
  wire [31:0] br8_target;
  wire [31:0] br12_target;
  wire [31:0] brreg_target;
  wire [31:0] imm_zx;
  wire [31:0] imm_sx;
  wire [31:0] trap_val;

  assign post_inc_val = selected_general_reg_in + size_bytes;
  assign pre_dec_val  = selected_general_reg_in - size_bytes;
  assign reg_disp_ea  = selected_general_reg_in + disp4_scaled;
  assign idx_reg_ea   = selected_general_reg_in + index_reg_zero_in;
  assign gbr_disp_ea  = global_base_reg_in + disp8_scaled;
  assign idx_gbr_ea   = global_base_reg_in + index_reg_zero_in;
  assign pc_base      = (pc_size == ea_gen_pkg::SIZE_LONG)
                        ? (pc_now & ea_gen_pkg::LONG_ALIGN_MSK) : pc_now;
  assign pc_load_ea   = pc_base + ea_gen_pkg::PC_AHEAD + pc_disp_scaled;
  assign br8_off      = {{23{disp_imm_in[7]}}, disp_imm_in[7:0], 1'h0};
  assign br12_off     = {{19{disp_imm_in[11]}}, disp_imm_in[11:0], 1'h0};
  assign br8_target   = pc_now + ea_gen_pkg::PC_AHEAD + br8_off;
  assign br12_target  = pc_now + ea_gen_pkg::PC_AHEAD + br12_off;
  assign brreg_target = pc_now + ea_gen_pkg::PC_AHEAD + selected_general_reg_in;
  assign imm_zx       = {24'h00_0000, disp_imm_in[7:0]};
  assign imm_sx       = {{24{disp_imm_in[7]}}, disp_imm_in[7:0]};
  assign trap_val     = imm_zx << ea_gen_pkg::TRAP_SHIFT;

  // one decode wire per mode keeps the selection flat and easy to trace
  wire is_direct;
  wire is_indirect;
  wire is_post_inc;
  wire is_pre_dec;
  wire is_reg_disp;
  wire is_idx_reg;
  wire is_gbr_disp;
  wire is_idx_gbr;
  wire is_pc_load;
  wire is_br8;
  wire is_br12;
  wire is_br_reg;
  wire is_imm_zx;
  wire is_imm_sx;
  wire is_imm_trap;

  wire is_operand;
  wire is_branch;
  wire is_mem;
  wire is_writeback;

  assign is_direct    = (mode_in == ea_gen_pkg::MODE_REG_DIRECT);
  assign is_indirect  = (mode_in == ea_gen_pkg::MODE_REG_INDIRECT);
  assign is_post_inc  = (mode_in == ea_gen_pkg::MODE_POST_INC);
  assign is_pre_dec   = (mode_in == ea_gen_pkg::MODE_PRE_DEC);
  assign is_reg_disp  = (mode_in == ea_gen_pkg::MODE_REG_DISP4);
  assign is_idx_reg   = (mode_in == ea_gen_pkg::MODE_INDEXED_REG);
  assign is_gbr_disp  = (mode_in == ea_gen_pkg::MODE_GBR_DISP8);
  assign is_idx_gbr   = (mode_in == ea_gen_pkg::MODE_INDEXED_GBR);
  assign is_pc_load   = (mode_in == ea_gen_pkg::MODE_PC_DISP8);
  assign is_br8       = (mode_in == ea_gen_pkg::MODE_BRANCH_DISP8);
  assign is_br12      = (mode_in == ea_gen_pkg::MODE_BRANCH_DISP12);
  assign is_br_reg    = (mode_in == ea_gen_pkg::MODE_BRANCH_REG);

  assign is_imm_zx    = (mode_in == ea_gen_pkg::MODE_IMM_ZERO);
  assign is_imm_sx    = (mode_in == ea_gen_pkg::MODE_IMM_SIGN);
  assign is_imm_trap  = (mode_in == ea_gen_pkg::MODE_IMM_TRAP);

  // the one unused code falls in no group and answers with kind none
  assign is_operand   = is_direct | is_imm_zx | is_imm_sx | is_imm_trap;
  assign is_branch    = is_br8 | is_br12 | is_br_reg;
  assign is_mem       = is_indirect | is_post_inc | is_pre_dec | is_reg_disp
                      | is_idx_reg | is_gbr_disp | is_idx_gbr | is_pc_load;
  assign is_writeback = is_post_inc | is_pre_dec;

  // selection of the result for the decoded mode
  wire [31:0]                    result_d;
  wire ea_gen_pkg::result_kind_t kind_d;
  wire                           wb_d;
  wire [31:0]                    wb_val_d;

  // decode wires are one-hot, so an and-or select needs no priority chain
  assign result_d = ({32{is_direct}}   & selected_general_reg_in)
                  | ({32{is_indirect}} & selected_general_reg_in)
                  | ({32{is_post_inc}} & selected_general_reg_in)
                  | ({32{is_pre_dec}}  & pre_dec_val)
                  | ({32{is_reg_disp}} & reg_disp_ea)
                  | ({32{is_idx_reg}}  & idx_reg_ea)
                  | ({32{is_gbr_disp}} & gbr_disp_ea)
                  | ({32{is_idx_gbr}}  & idx_gbr_ea)
                  | ({32{is_pc_load}}  & pc_load_ea)
                  | ({32{is_br8}}      & br8_target)
                  | ({32{is_br12}}     & br12_target)
                  | ({32{is_br_reg}}   & brreg_target)
                  | ({32{is_imm_zx}}   & imm_zx)
                  | ({32{is_imm_sx}}   & imm_sx)
                  | ({32{is_imm_trap}} & trap_val);

  // kind none on the unused code lets the caller spot a decoder fault
  assign kind_d   = is_operand ? ea_gen_pkg::RESULT_OPERAND
                  : is_branch  ? ea_gen_pkg::RESULT_BRANCH
                  : is_mem     ? ea_gen_pkg::RESULT_MEM_ADDR
                  :              ea_gen_pkg::RESULT_NONE;

  // without a writeback the value simply mirrors the register
  assign wb_d     = is_writeback;
  assign wb_val_d = is_pre_dec  ? pre_dec_val
                  : is_post_inc ? post_inc_val
                  :               selected_general_reg_in;

  wire mem_d;
  wire xlate_d;
  wire address_space_id_d;
  assign mem_d   = (kind_d == ea_gen_pkg::RESULT_MEM_ADDR);
  assign xlate_d = mem_d & addr_translate_enable_in;
  assign address_space_id_d  = xlate_d & ~single_virtual_space_in;

  // next values of the answer; pulses follow only a taken start
  wire       valid_d;
  wire       mem_pulse_d;
  wire       wb_pulse_d;
  wire       xlate_pulse_d;
  wire       address_space_id_pulse_d;
  wire [7:0] address_space_id_word_d;

  assign valid_d       = start_in;
  assign mem_pulse_d   = start_in & mem_d;
  assign wb_pulse_d    = start_in & wb_d;
  assign xlate_pulse_d = start_in & xlate_d;
  assign address_space_id_pulse_d  = start_in & address_space_id_d;
  // the space id loads as zero on each start that does not present it
  assign address_space_id_word_d   = address_space_id_d ? page_entry_high_reg_in[7:0]
                                : ea_gen_pkg::RESET_ADDRESS_SPACE_ID;

  // one registered answer per start; a held start gives one per cycle
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      valid_out <= 1'h0;
    end else begin
      valid_out <= valid_d;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      mem_access_out <= 1'h0;
    end else begin
      mem_access_out <= mem_pulse_d;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      base_wb_out <= 1'h0;
    end else begin
      base_wb_out <= wb_pulse_d;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      translate_out <= 1'h0;
    end else begin
      translate_out <= xlate_pulse_d;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      address_space_id_valid_out <= 1'h0;
    end else begin
      address_space_id_valid_out <= address_space_id_pulse_d;
    end
  end

  // held words change only on a taken start, so they may be read late
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      kind_out <= ea_gen_pkg::RESULT_NONE;
    end else if (start_in) begin
      kind_out <= kind_d;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      result_out <= ea_gen_pkg::RESET_WORD;
    end else if (start_in) begin
      result_out <= result_d;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      base_wb_value_out <= ea_gen_pkg::RESET_WORD;
    end else if (start_in) begin
      base_wb_value_out <= wb_val_d;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      address_space_id_out <= ea_gen_pkg::RESET_ADDRESS_SPACE_ID;
    end else if (start_in) begin
      address_space_id_out <= address_space_id_word_d;
    end
  end

endmodule

//--- rtl/size_step.sv
// converts an operand size into its byte count 1/2/4/8
module size_step (
  input  wire ea_gen_pkg::op_size_t size_in,
  output wire logic [31:0]          step_out
);
  assign step_out = 32'h0000_0001 << size_in;
endmodule

//--- verification/ea_decoder_model.sv
module ea_decoder_model (
  input  wire logic              clk_in,
  output logic                   start_out,
  output ea_gen_pkg::addr_mode_t mode_out,
  output ea_gen_pkg::op_size_t   size_out,
  output logic [31:0]            sel_out,
  output logic [31:0]            idx_out,
  output logic [31:0]            gbase_out,
  output logic [31:0]            pc_out,
  output logic [11:0]            disp_out,
  output logic                   xlate_out,
  output logic                   one_space_out,
  output logic [31:0]            entry_hi_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {start_out, sel_out, idx_out, gbase_out, pc_out, disp_out} = '0;
    {xlate_out, one_space_out, entry_hi_out} = '0;
    mode_out = ea_gen_pkg::MODE_REG_DIRECT;
    size_out = ea_gen_pkg::SIZE_BYTE;
  end
  task mmu(input logic x, input logic s, input logic [31:0] e);
    @(posedge clk_in);
    xlate_out <= x;
    one_space_out <= s;
    entry_hi_out <= e;
  endtask
  task issue(input ea_gen_pkg::addr_mode_t m, input ea_gen_pkg::op_size_t s,
             input logic [31:0] r, input logic [31:0] x, input logic [11:0] d);
    @(posedge clk_in);
    start_out <= 1'b1;
    mode_out <= m;
    size_out <= s;
    sel_out <= r;
    idx_out <= x;
    gbase_out <= ~r;
    pc_out <= r + 32'h2;
    disp_out <= d;
    @(posedge clk_in);
    start_out <= 1'b0;
    // fields scrambled once taken, so a late sample shows up
    sel_out <= ~r;
    idx_out <= ~x;
    pc_out <= ~pc_out;
    disp_out <= ~d;
  endtask
endmodule

//--- verification/ea_gen_monitor.sv
module ea_gen_monitor (
  input wire logic                   core_clk_in,
  input wire logic                   srst_in,
  input wire logic                   start_in,
  input wire ea_gen_pkg::addr_mode_t mode_in,
  input wire ea_gen_pkg::op_size_t   size_in,
  input wire logic [31:0]            selected_general_reg_in,
  input wire logic [31:0]            index_reg_zero_in,
  input wire logic [31:0]            global_base_reg_in,
  input wire logic [31:0]            pc_in,
  input wire logic [11:0]            disp_imm_in,
  input wire logic                   addr_translate_enable_in,
  input wire logic [31:0]            page_entry_high_reg_in,
  input wire logic                   valid_out,
  input wire logic [31:0]            result_out,
  input wire logic                   mem_access_out,
  input wire logic                   base_wb_out,
  input wire logic [31:0]            base_wb_value_out,
  input wire logic                   translate_out,
  input wire logic                   address_space_id_valid_out,
  input wire logic [7:0]             address_space_id_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);
  property p_direct;
    start_in && mode_in == ea_gen_pkg::MODE_REG_DIRECT |=> valid_out && !mem_access_out
      && result_out == $past(selected_general_reg_in);
  endproperty
  property p_post;
    start_in && mode_in == ea_gen_pkg::MODE_POST_INC |=> base_wb_out
      && result_out == $past(selected_general_reg_in)
      && base_wb_value_out == $past(selected_general_reg_in) + (32'h1 << $past(size_in));
  endproperty
  property p_pre;
    start_in && mode_in == ea_gen_pkg::MODE_PRE_DEC |=> result_out == base_wb_value_out
      && result_out == $past(selected_general_reg_in) - (32'h1 << $past(size_in));
  endproperty
  property p_idx;
    start_in && mode_in == ea_gen_pkg::MODE_INDEXED_REG |=> mem_access_out
      && result_out == $past(selected_general_reg_in) + $past(index_reg_zero_in);
  endproperty
  property p_idxg;
    start_in && mode_in == ea_gen_pkg::MODE_INDEXED_GBR |=>
      result_out == $past(global_base_reg_in) + $past(index_reg_zero_in);
  endproperty
  property p_br12;
    start_in && mode_in == ea_gen_pkg::MODE_BRANCH_DISP12 |=> result_out == $past(pc_in)
      + 32'h4 + {{19{$past(disp_imm_in[11])}}, $past(disp_imm_in), 1'b0};
  endproperty
  property p_trap;
    start_in && mode_in == ea_gen_pkg::MODE_IMM_TRAP |=>
      result_out == ((32'($past(disp_imm_in)) & 32'hFF) << 2);
  endproperty
  property p_xlate;
    valid_out |-> translate_out == (mem_access_out && $past(addr_translate_enable_in));
  endproperty
  property p_address_space_id;
    address_space_id_valid_out |-> translate_out
      && address_space_id_out == 8'($past(page_entry_high_reg_in));
  endproperty
  a_direct: assert property (p_direct) else $error("direct operand wrong");
  a_post: assert property (p_post) else $error("post-increment wrong");
  a_pre: assert property (p_pre) else $error("predecrement wrong");
  a_idx: assert property (p_idx) else $error("indexed address wrong");
  a_idxg: assert property (p_idxg) else $error("indexed global wrong");
  a_br12: assert property (p_br12) else $error("long branch wrong");
  a_trap: assert property (p_trap) else $error("trap value wrong");
  a_xlate: assert property (p_xlate) else $error("translate flag wrong");
  a_address_space_id: assert property (p_address_space_id) else $error("space id wrong");
  c_post: cover property (start_in && mode_in == ea_gen_pkg::MODE_POST_INC);
  c_address_space_id: cover property (address_space_id_valid_out);
  c_branch: cover property (start_in && mode_in == ea_gen_pkg::MODE_BRANCH_REG);
endmodule

//--- verification/effective_address_generator_test.sv
module effective_address_generator_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk_in = 1'b0;
  logic srst_in = 1'b1;
  int errors = 0;
  int samples_checked = 0;
  wire logic start_in, addr_translate_enable_in, single_virtual_space_in;
  wire ea_gen_pkg::addr_mode_t mode_in;
  wire ea_gen_pkg::op_size_t size_in;
  wire logic [31:0] selected_general_reg_in, index_reg_zero_in, global_base_reg_in;
  wire logic [31:0] pc_in, page_entry_high_reg_in, result_out, base_wb_value_out;
  wire logic [11:0] disp_imm_in;
  wire logic valid_out, mem_access_out, base_wb_out, translate_out, address_space_id_valid_out;
  wire ea_gen_pkg::result_kind_t kind_out;
  wire logic [7:0] address_space_id_out;
  always #20 core_clk_in = ~core_clk_in;
  effective_address_generator i_dut (.*);
  ea_decoder_model i_dec (.clk_in(core_clk_in), .start_out(start_in), .mode_out(mode_in),
    .size_out(size_in), .sel_out(selected_general_reg_in), .idx_out(index_reg_zero_in),
    .gbase_out(global_base_reg_in), .pc_out(pc_in), .disp_out(disp_imm_in),
    .xlate_out(addr_translate_enable_in), .one_space_out(single_virtual_space_in),
    .entry_hi_out(page_entry_high_reg_in));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic op(input ea_gen_pkg::addr_mode_t m, input int s, input logic [31:0] r,
                    input logic [31:0] x, input logic [11:0] d, input logic [31:0] e);
    i_dec.issue(m, ea_gen_pkg::op_size_t'(s), r, x, d);
    // issue returns on the taking edge; pulses stand only until the next one
    #1;
    check(valid_out, 32'h1);
    check(result_out, e);
  endtask
  task automatic t_modes;
    logic [31:0] r;
    r = 32'h8000_1000;
    op(ea_gen_pkg::MODE_REG_DIRECT, 2, r, 0, 0, r);
    check(mem_access_out, 0);
    check(kind_out, ea_gen_pkg::RESULT_OPERAND);
    for (int s = 0; s < 4; s++) begin
      op(ea_gen_pkg::MODE_POST_INC, s, r, 0, 0, r);
      check(base_wb_value_out, r + (32'h1 << s));
      op(ea_gen_pkg::MODE_PRE_DEC, s, 32'h2, 0, 0, 32'h2 - (32'h1 << s));
      check(base_wb_out, 1);
      check(base_wb_value_out, 32'h2 - (32'h1 << s));
    end
    for (int s = 0; s < 3; s++) begin
      op(ea_gen_pkg::MODE_REG_DISP4, s, r, 0, 12'hFFF, r + (32'hF << s));
      op(ea_gen_pkg::MODE_GBR_DISP8, s, r, 0, 12'hFFF, ~r + (32'hFF << s));
    end
    op(ea_gen_pkg::MODE_INDEXED_REG, 0, r, 32'h9000_0004, 0, r + 32'h9000_0004);
    op(ea_gen_pkg::MODE_INDEXED_GBR, 0, r, 32'h5, 0, ~r + 32'h5);
    $display("t_modes done");
  endtask
  task automatic t_pc;
    logic [31:0] r;
    r = 32'hFFFF_FF01;
    op(ea_gen_pkg::MODE_PC_DISP8, 1, r, 0, 12'h080, r + 32'h106);
    op(ea_gen_pkg::MODE_PC_DISP8, 2, r, 0, 12'h080, ((r + 2) & 32'hFFFF_FFFC) + 32'h204);
    op(ea_gen_pkg::MODE_BRANCH_DISP8, 0, r, 0, 12'h0FE, r + 32'h2);
    op(ea_gen_pkg::MODE_BRANCH_DISP12, 0, r, 0, 12'h800, r - 32'hFFA);
    op(ea_gen_pkg::MODE_BRANCH_REG, 0, r, 0, 0, r + r + 32'h6);
    check(kind_out, ea_gen_pkg::RESULT_BRANCH);
    $display("t_pc done");
  endtask
  task automatic t_imm;
    op(ea_gen_pkg::MODE_IMM_ZERO, 0, 0, 0, 12'hF80, 32'h80);
    op(ea_gen_pkg::MODE_IMM_SIGN, 0, 0, 0, 12'h080, 32'hFFFF_FF80);
    op(ea_gen_pkg::MODE_IMM_TRAP, 0, 0, 0, 12'hFFF, 32'h3FC);
    $display("t_imm done");
  endtask
  task automatic t_mmu;
    i_dec.mmu(1'h1, 1'h0, 32'hA5A5_A53C);
    op(ea_gen_pkg::MODE_REG_INDIRECT, 2, 32'h40, 0, 0, 32'h40);
    check(translate_out, 1);
    check(kind_out, ea_gen_pkg::RESULT_MEM_ADDR);
    check({address_space_id_valid_out, address_space_id_out}, 32'h13C);
    i_dec.mmu(1'h1, 1'h1, 32'h0);
    op(ea_gen_pkg::MODE_REG_INDIRECT, 2, 32'h40, 0, 0, 32'h40);
    check(address_space_id_valid_out, 0);
    check(address_space_id_out, 0);
    op(ea_gen_pkg::MODE_REG_DIRECT, 2, 32'h40, 0, 0, 32'h40);
    check(translate_out, 0);
    op(ea_gen_pkg::addr_mode_t'(4'hF), 0, 32'h40, 0, 0, 32'h0);
    check(translate_out, 0);
    check(kind_out, ea_gen_pkg::RESULT_NONE);
    i_dec.mmu(1'h0, 1'h0, 32'h0);
    op(ea_gen_pkg::MODE_REG_INDIRECT, 2, 32'h40, 0, 0, 32'h40);
    check(translate_out, 0);
    $display("t_mmu done");
  endtask
  task automatic tally_and_finish;
    $display("checked %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge core_clk_in);
    srst_in <= 1'b0;
    t_modes;
    t_pc;
    t_imm;
    t_mmu;
    tally_and_finish;
  end
  initial begin
    repeat (2000) @(posedge core_clk_in);
    errors++;
    tally_and_finish;
  end
endmodule
bind effective_address_generator ea_gen_monitor i_mon (.*);
